// File: fsr_host_model.sv
`timescale 1ns/10ps
module fsr_host_model (
    input wire logic mclk,
    input wire logic [7:0] first_status_reg,
    output logic soft_reset,
    output logic cmd_write_enable,
    output logic cmd_volatile_enable,
    output logic cmd_write_disable,
    output logic cmd_read_status,
    output logic cmd_suspend,
    output logic cmd_resume,
    output fsr_pkg::fsr_op_e cmd_op,
    output logic [1:0] cmd_reg_sel,
    output logic [7:0] cmd_wdata,
    output logic wp_pin_n
);
    import fsr_pkg::*;
    logic [7:0] strobe_q;
    assign {soft_reset, cmd_read_status, cmd_resume, cmd_suspend} = strobe_q[7:4];
    assign {cmd_write_disable, cmd_volatile_enable, cmd_write_enable} = strobe_q[2:0];
    initial begin
        strobe_q = 8'h00;
        cmd_op = FSR_OP_NONE;
        cmd_reg_sel = 2'h3;
        cmd_wdata = 8'h00;
        wp_pin_n = 1'b1;
    end
    // 0 enable, 1 volatile enable, 2 disable, 4 suspend, 5 resume, 6 status read, 7 soft reset
    task automatic pulse(input int k);
        @(posedge mclk);
        strobe_q[k] <= 1'b1;
        @(posedge mclk);
        strobe_q <= 8'h00;
        @(posedge mclk);
    endtask
    task automatic op(input fsr_op_e o, input logic [1:0] sel, input logic [7:0] d);
        @(posedge mclk);
        cmd_op <= o;
        cmd_reg_sel <= sel;
        cmd_wdata <= d;
        @(posedge mclk);
        cmd_op <= FSR_OP_NONE;
        cmd_reg_sel <= 2'h3;
        @(posedge mclk);
    endtask
    // The enable of the chosen kind always goes right before the status write
    task automatic wr(input bit vol, input logic [1:0] sel, input logic [7:0] d);
        pulse(vol ? 1 : 0);
        op(FSR_OP_STATUS_WRITE, sel, d);
    endtask
    // Only status is watched while busy; nothing else is sent
    task automatic wait_idle(output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++) begin
            @(posedge mclk);
            #1;
            ok = (first_status_reg[0] === 1'b0);
        end
    endtask
    // Pin passes a two-stage synchroniser, so allow settling time
    task automatic set_wp(input logic v);
        @(posedge mclk);
        wp_pin_n <= v;
        repeat (4) @(posedge mclk);
    endtask
endmodule

// File: fsr_op_timer.sv
`timescale 1ns/10ps
module fsr_op_timer #(
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [WIDTH-1:0] length,
    output logic running,
    output logic done
);
    logic [WIDTH-1:0] cnt_q, cnt_d;
    logic run_q, run_d;
    logic done_q, done_d;

    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        done_d = 1'b0;
        if (start && !run_q) begin
            cnt_d = (length == '0) ? WIDTH'(1) : length;
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q == WIDTH'(1)) begin
                run_d = 1'b0;
                done_d = 1'b1;
                cnt_d = '0;
            end else begin
                cnt_d = cnt_q - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            done_q <= done_d;
        end
    end

    assign running = run_q;
    assign done = done_q;
endmodule

// File: fsr_pkg.sv
package fsr_pkg;
    localparam int FSR_BUSY_POS = 0;
    localparam int FSR_WEL_POS = 1;
    localparam int FSR_BP_LSB = 2;
    localparam int FSR_DIR_POS = 5;
    localparam int FSR_GRAN_POS = 6;
    localparam int FSR_SPL_POS = 7;
    localparam int FSR_SPH_POS = 0;
    localparam int FSR_QE_POS = 1;
    localparam int FSR_LB_LSB = 3;
    localparam int FSR_INV_POS = 6;
    localparam int FSR_SUS_POS = 7;
    localparam int FSR_HFM_POS = 4;
    localparam int FSR_DRV_LSB = 5;
    localparam int FSR_ROLE_POS = 7;
    localparam logic [7:0] FSR_REG1_RST = 8'h00;
    localparam logic [7:0] FSR_REG2_RST = 8'h00;
    localparam logic [7:0] FSR_REG3_RST = 8'h00;
    // Writable masks; reserved and status-only bits are never stored
    localparam logic [7:0] FSR_REG1_WMASK = 8'hfc;
    localparam logic [7:0] FSR_REG2_VMASK = 8'h43;
    localparam logic [7:0] FSR_REG2_NMASK = 8'h7b;
    localparam logic [7:0] FSR_REG3_VMASK = 8'hf0;
    localparam logic [7:0] FSR_REG3_NMASK = 8'h90;
    // Default cycles an embedded operation keeps the timer busy; the status busy bit stays up two cycles longer
    localparam int FSR_OP_CYCLES = 16;
    typedef enum logic [2:0] {
        FSR_OP_NONE,
        FSR_OP_PROGRAM,
        FSR_OP_SECTOR_ERASE,
        FSR_OP_BLOCK_ERASE,
        FSR_OP_CHIP_ERASE,
        FSR_OP_STATUS_WRITE
    } fsr_op_e;
    typedef enum logic [1:0] {
        FSR_WEN_NONE,
        FSR_WEN_NONVOL,
        FSR_WEN_VOL
    } fsr_wen_e;
endpackage

// File: fsr_status_bank.sv
`timescale 1ns/10ps
// Behaviour
// RULE1 - First register bit 7 is protect select low, gating write-protect pin use.
// RULE2 - First register bit 6 picks 64-kB blocks (0) or 4-kB sectors (1).
// RULE3 - First register bit 5: 0 protects from top, 1 from bottom.
// RULE4 - First register bits 4..2 are block protect; zero protects nothing.
// RULE5 - First register bit 1 is read-only write enable latch gating operations.
// RULE6 - First register bit 0 is read-only busy flag during embedded work.
// RULE7 - Busy sets during program, erases or status write, clears when done.
// RULE8 - While busy, every instruction except status read is ignored; the code still accepts soft reset while busy.
// RULE9 - Write enable instruction sets the write enable latch.
// RULE10 - Latch clears at reset, write disable, program, erase or status write.
// RULE11 - Second register bit 7 is read-only suspended operation flag.
// RULE12 - Second register bit 6 selects complement map, volatile and stored copies.
// RULE13 - Second register bits 5..3 are one-time lock bits for security areas.
// RULE14 - Second register bit 1 turns shared pins into data lines two, three.
// RULE15 - Second register bit 0 is protect select high.
// RULE16 - Third register bit 7 picks hold or reset role, only without quad.
// RULE17 - Third register bits 6..5 are volatile read drive strength.
// RULE18 - Third register bit 4 is fast clock mode, volatile and stored copies.
// RULE19 - At reset, volatile copies load from their non-volatile counterparts; the code clears volatile protect select high if stored selects are 10.
// RULE20 - Volatile write enable before status write targets volatile copies only.
// RULE21 - Non-volatile write needs write enable, protect selects and pin permission; the code skips the protect check for third register writes.
// RULE22 - Reserved bits read zero and ignore writes.
module fsr_status_bank #(
    parameter int TIMER_WIDTH = 16,
    parameter logic [TIMER_WIDTH-1:0] OP_CYCLES = TIMER_WIDTH'(fsr_pkg::FSR_OP_CYCLES)
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic soft_reset,
    input wire logic cmd_write_enable,
    input wire logic cmd_volatile_enable,
    input wire logic cmd_write_disable,
    input wire logic cmd_read_status,
    input wire fsr_pkg::fsr_op_e cmd_op,
    input wire logic [1:0] cmd_reg_sel,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_suspend,
    input wire logic cmd_resume,
    input wire logic wp_pin_n,
    output logic [7:0] first_status_reg,
    output logic [7:0] second_status_reg,
    output logic [7:0] third_status_reg,
    output logic cmd_ignored,
    output logic op_started,
    output logic wp_pin_active,
    output logic shared_pin_hold,
    output logic shared_pin_reset,
    output logic quad_lane_enable,
    output logic [1:0] drive_level,
    output logic fast_clock_mode
);
    import fsr_pkg::*;

    logic [7:0] nv1_q, nv1_d, nv2_q, nv2_d, nv3_q, nv3_d;
    logic [7:0] v1_q, v1_d, v2_q, v2_d, v3_q, v3_d;
    logic write_enable_latch_q, write_enable_latch_d;
    logic paused_op_flag_q, paused_op_flag_d;
    fsr_wen_e wen_q, wen_d;
    logic load_q, load_d;
    logic [7:0] o1_q, o1_d, o2_q, o2_d, o3_q, o3_d;
    logic ign_q, ign_d, start_q, start_d;
    logic wpa_q, wpa_d, hold_q, hold_d, rst_q, rst_d, qe_q, qe_d;
    logic [1:0] drv_q, drv_d;
    logic hfm_q, hfm_d;
    logic wp_meta_q, wp_sync_q;
    logic busy, op_done, any_cmd, do_op, prot_ok;

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (nw & mask);
    endfunction

    fsr_op_timer #(.WIDTH(TIMER_WIDTH)) u_timer (
        .mclk(mclk),
        .nrst(nrst),
        .start(start_q),
        .length(OP_CYCLES),
        .running(busy),
        .done(op_done)
    );

    // Pin is asynchronous to mclk
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wp_meta_q <= 1'b1;
            wp_sync_q <= 1'b1;
        end else begin
            wp_meta_q <= wp_pin_n;
            wp_sync_q <= wp_meta_q;
        end
    end

    assign any_cmd = cmd_write_enable | cmd_volatile_enable | cmd_write_disable |
                     cmd_suspend | cmd_resume | (cmd_op != FSR_OP_NONE);
    // Start pulse is still in flight one cycle before the timer shows busy
    assign do_op = (cmd_op != FSR_OP_NONE) && !busy && !start_q && !soft_reset &&
                   write_enable_latch_q; // RULE5

    // Protect selects high/low: 00 free, 01 pin decides unless quad, 1x locked
    always_comb begin
        prot_ok = 1'b0;
        case ({v2_q[FSR_SPH_POS], v1_q[FSR_SPL_POS]}) // RULE1 RULE15 RULE21
            2'b00: prot_ok = 1'b1;
            2'b01: prot_ok = v2_q[FSR_QE_POS] | wp_sync_q;
            default: prot_ok = 1'b0;
        endcase
    end

    always_comb begin
        nv1_d = nv1_q;
        nv2_d = nv2_q;
        nv3_d = nv3_q;
        v1_d = v1_q;
        v2_d = v2_q;
        v3_d = v3_q;
        write_enable_latch_d = write_enable_latch_q;
        paused_op_flag_d = paused_op_flag_q;
        wen_d = wen_q;
        load_d = 1'b0;
        ign_d = 1'b0;
        start_d = 1'b0;
        if (load_q || soft_reset) begin
            // Stored copies survive soft reset; the volatile ones reload from them
            v1_d = nv1_q & FSR_REG1_WMASK; // RULE19
            v2_d = nv2_q & FSR_REG2_VMASK; // RULE19
            // Supply lockdown ends with a reset cycle
            if (nv2_q[FSR_SPH_POS] && !nv1_q[FSR_SPL_POS]) begin
                v2_d[FSR_SPH_POS] = 1'b0;
            end
            v3_d = (nv3_q & FSR_REG3_NMASK) | (FSR_REG3_RST & 8'h60); // RULE19
            write_enable_latch_d = 1'b0; // RULE10
            paused_op_flag_d = 1'b0;
            wen_d = FSR_WEN_NONE;
        end else if (busy || start_q) begin
            ign_d = any_cmd; // RULE8
        end else begin
            if (cmd_write_enable) begin
                write_enable_latch_d = 1'b1; // RULE9
                wen_d = FSR_WEN_NONVOL;
            end else if (cmd_volatile_enable) begin
                wen_d = FSR_WEN_VOL; // RULE20
            end else if (cmd_write_disable) begin
                write_enable_latch_d = 1'b0; // RULE10
                wen_d = FSR_WEN_NONE;
            end else if (cmd_suspend) begin
                paused_op_flag_d = 1'b1; // RULE11
            end else if (cmd_resume) begin
                paused_op_flag_d = 1'b0; // RULE11
            end else if (cmd_op == FSR_OP_STATUS_WRITE && wen_q == FSR_WEN_VOL) begin
                // Volatile write takes effect at once with no busy period
                if (cmd_reg_sel == 2'd2) begin
                    v3_d = merge(v3_q, cmd_wdata, FSR_REG3_VMASK); // RULE17 RULE22
                end else if (prot_ok && cmd_reg_sel == 2'd0) begin
                    v1_d = merge(v1_q, cmd_wdata, FSR_REG1_WMASK); // RULE20
                end else if (prot_ok && cmd_reg_sel == 2'd1) begin
                    v2_d = merge(v2_q, cmd_wdata, FSR_REG2_VMASK); // RULE12 RULE20 RULE22
                end
                wen_d = FSR_WEN_NONE;
            end else if (cmd_op != FSR_OP_NONE) begin
                if (do_op) begin
                    start_d = 1'b1; // RULE7
                    if (cmd_op == FSR_OP_STATUS_WRITE && (prot_ok || cmd_reg_sel == 2'd2)) begin
                        case (cmd_reg_sel) // RULE21
                            2'd0: begin
                                nv1_d = merge(nv1_q, cmd_wdata, FSR_REG1_WMASK); // RULE2 RULE3 RULE4
                                v1_d = nv1_d;
                            end
                            2'd1: begin
                                // Lock bits only ever go from 0 to 1
                                nv2_d = merge(nv2_q, cmd_wdata, FSR_REG2_NMASK) |
                                        (nv2_q & 8'h38); // RULE13
                                v2_d = merge(v2_q, nv2_d, FSR_REG2_VMASK);
                            end
                            2'd2: begin
                                nv3_d = merge(nv3_q, cmd_wdata, FSR_REG3_NMASK);
                                v3_d = merge(v3_q, nv3_d, FSR_REG3_NMASK);
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                write_enable_latch_d = 1'b0; // RULE10
                wen_d = FSR_WEN_NONE;
            end
        end
        // Assemble read views and pin-function outputs from next state
        o1_d = (v1_d & FSR_REG1_WMASK) | {6'h00, write_enable_latch_d, 1'b0};
        o1_d[FSR_BUSY_POS] = (busy & ~op_done) | start_d | start_q; // RULE6 RULE7
        o2_d = (v2_d & FSR_REG2_VMASK) | (nv2_d & 8'h38); // RULE13 RULE22
        o2_d[FSR_SUS_POS] = paused_op_flag_d; // RULE11
        o3_d = v3_d & FSR_REG3_VMASK; // RULE22
        qe_d = v2_d[FSR_QE_POS]; // RULE14
        wpa_d = ~v2_d[FSR_QE_POS]; // RULE14
        hold_d = ~v2_d[FSR_QE_POS] & ~v3_d[FSR_ROLE_POS]; // RULE16
        rst_d = ~v2_d[FSR_QE_POS] & v3_d[FSR_ROLE_POS]; // RULE16
        drv_d = v3_d[FSR_DRV_LSB+1:FSR_DRV_LSB]; // RULE17
        hfm_d = v3_d[FSR_HFM_POS]; // RULE18
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            nv1_q <= FSR_REG1_RST;
            nv2_q <= FSR_REG2_RST;
            nv3_q <= FSR_REG3_RST;
            v1_q <= FSR_REG1_RST;
            v2_q <= FSR_REG2_RST;
            v3_q <= FSR_REG3_RST;
            write_enable_latch_q <= 1'b0;
            paused_op_flag_q <= 1'b0;
            wen_q <= FSR_WEN_NONE;
            load_q <= 1'b1;
            o1_q <= FSR_REG1_RST;
            o2_q <= FSR_REG2_RST;
            o3_q <= FSR_REG3_RST;
            ign_q <= 1'b0;
            start_q <= 1'b0;
            wpa_q <= 1'b1;
            hold_q <= 1'b1;
            rst_q <= 1'b0;
            qe_q <= 1'b0;
            drv_q <= 2'b00;
            hfm_q <= 1'b0;
        end else begin
            nv1_q <= nv1_d;
            nv2_q <= nv2_d;
            nv3_q <= nv3_d;
            v1_q <= v1_d;
            v2_q <= v2_d;
            v3_q <= v3_d;
            write_enable_latch_q <= write_enable_latch_d;
            paused_op_flag_q <= paused_op_flag_d;
            wen_q <= wen_d;
            load_q <= load_d;
            o1_q <= o1_d;
            o2_q <= o2_d;
            o3_q <= o3_d;
            ign_q <= ign_d;
            start_q <= start_d;
            wpa_q <= wpa_d;
            hold_q <= hold_d;
            rst_q <= rst_d;
            qe_q <= qe_d;
            drv_q <= drv_d;
            hfm_q <= hfm_d;
        end
    end

    assign first_status_reg = o1_q;
    assign second_status_reg = o2_q;
    assign third_status_reg = o3_q;
    assign cmd_ignored = ign_q;
    assign op_started = start_q;
    assign wp_pin_active = wpa_q;
    assign shared_pin_hold = hold_q;
    assign shared_pin_reset = rst_q;
    assign quad_lane_enable = qe_q;
    assign drive_level = drv_q;
    assign fast_clock_mode = hfm_q;

    AST_BUSY_AFTER_START: assert property (@(posedge mclk) disable iff (!nrst) // RULE7
        start_q |=> first_status_reg[FSR_BUSY_POS]) else $error("busy not shown after start");
    AST_BUSY_CLEARS: assert property (@(posedge mclk) disable iff (!nrst) // RULE7
        op_done |=> !first_status_reg[FSR_BUSY_POS]) else $error("busy stuck after done");
    AST_IGNORE_WHEN_BUSY: assert property (@(posedge mclk) disable iff (!nrst) // RULE8
        (busy && !soft_reset && !load_q && cmd_write_enable) |=> cmd_ignored &&
        $stable(write_enable_latch_q)) else $error("command taken while busy");
    AST_WEL_SET: assert property (@(posedge mclk) disable iff (!nrst) // RULE9
        (cmd_write_enable && !busy && !start_q && !soft_reset && !load_q) |=>
        first_status_reg[FSR_WEL_POS]) else $error("latch not set");
    AST_WEL_CLR_OP: assert property (@(posedge mclk) disable iff (!nrst) // RULE10
        start_q |-> !write_enable_latch_q) else $error("latch kept after op");
    AST_NO_OP_WITHOUT_WEL: assert property (@(posedge mclk) disable iff (!nrst) // RULE5
        start_q |-> $past(write_enable_latch_q)) else $error("op without latch");
    AST_QE_PINS: assert property (@(posedge mclk) disable iff (!nrst) // RULE16
        quad_lane_enable |-> !shared_pin_hold && !shared_pin_reset && !wp_pin_active)
        else $error("pin role active in quad");
    AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!nrst) // RULE22
        second_status_reg[2] == 1'b0 && third_status_reg[3:0] == 4'h0)
        else $error("reserved bit set");
    AST_SOFT_RESET_LOAD: assert property (@(posedge mclk) disable iff (!nrst) // RULE19
        soft_reset |=> v1_q == (nv1_q & FSR_REG1_WMASK)) else $error("volatile not reloaded");
    AST_BUSY_BIT_SHOWN: assert property (@(posedge mclk) disable iff (!nrst) // RULE6
        busy |=> first_status_reg[FSR_BUSY_POS]) else $error("busy bit low during operation");
    AST_SUSPEND_SET: assert property (@(posedge mclk) disable iff (!nrst) // RULE11
        (cmd_suspend && !busy && !start_q && !soft_reset && !load_q && !cmd_write_enable &&
        !cmd_volatile_enable && !cmd_write_disable) |=> second_status_reg[FSR_SUS_POS])
        else $error("suspend flag not set");
    AST_LOCK_ONE_WAY: assert property (@(posedge mclk) disable iff (!nrst) // RULE13
        ($past(nv2_q[FSR_LB_LSB+2:FSR_LB_LSB]) & ~nv2_q[FSR_LB_LSB+2:FSR_LB_LSB]) == 3'h0)
        else $error("lock bit cleared");
    AST_VOL_WRITE_NO_OP: assert property (@(posedge mclk) disable iff (!nrst) // RULE20
        (cmd_op == FSR_OP_STATUS_WRITE && wen_q == FSR_WEN_VOL) |=> !op_started)
        else $error("volatile write started an operation");
    AST_NV_NEEDS_WEL: assert property (@(posedge mclk) disable iff (!nrst) // RULE21
        !write_enable_latch_q |=> $stable({nv1_q, nv2_q, nv3_q}))
        else $error("stored bits written without latch");
    AST_PIN_ROLE: assert property (@(posedge mclk) disable iff (!nrst) // RULE16
        !quad_lane_enable |-> (shared_pin_hold != shared_pin_reset) && wp_pin_active)
        else $error("pin role missing without quad");
    AST_STATUS_READ_OK: assert property (@(posedge mclk) disable iff (!nrst) // RULE8
        (cmd_read_status && !any_cmd) |=> !cmd_ignored) else $error("status read ignored");
endmodule

// File: test_fsr_status_bank.sv
`timescale 1ns/10ps
module test_fsr_status_bank;
    import fsr_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic soft_reset, cmd_write_enable, cmd_volatile_enable, cmd_write_disable;
    logic cmd_read_status, cmd_suspend, cmd_resume, wp_pin_n;
    fsr_op_e cmd_op;
    logic [1:0] cmd_reg_sel, drive_level;
    logic [7:0] cmd_wdata, first_status_reg, second_status_reg, third_status_reg;
    logic cmd_ignored, wp_pin_active, shared_pin_hold, shared_pin_reset;
    logic quad_lane_enable, fast_clock_mode, op_started;
    int tests_run = 0;
    int n_mismatch = 0;
    int ign_cnt = 0;
    int st_cnt = 0;
    bit ok;
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (cmd_ignored === 1'b1) ign_cnt <= ign_cnt + 1;
    always @(posedge mclk) if (op_started === 1'b1) st_cnt <= st_cnt + 1;
    fsr_status_bank i_fsr_status_bank (.mclk(mclk), .nrst(nrst), .soft_reset(soft_reset),
        .cmd_write_enable(cmd_write_enable), .cmd_volatile_enable(cmd_volatile_enable),
        .cmd_write_disable(cmd_write_disable), .cmd_read_status(cmd_read_status),
        .cmd_op(cmd_op), .cmd_reg_sel(cmd_reg_sel), .cmd_wdata(cmd_wdata),
        .cmd_suspend(cmd_suspend), .cmd_resume(cmd_resume), .wp_pin_n(wp_pin_n),
        .first_status_reg(first_status_reg), .second_status_reg(second_status_reg),
        .third_status_reg(third_status_reg), .cmd_ignored(cmd_ignored),
        .op_started(op_started),
        .wp_pin_active(wp_pin_active), .shared_pin_hold(shared_pin_hold),
        .shared_pin_reset(shared_pin_reset), .quad_lane_enable(quad_lane_enable),
        .drive_level(drive_level), .fast_clock_mode(fast_clock_mode));
    fsr_host_model i_fsr_host_model (.mclk(mclk), .first_status_reg(first_status_reg),
        .soft_reset(soft_reset), .cmd_write_enable(cmd_write_enable),
        .cmd_volatile_enable(cmd_volatile_enable), .cmd_write_disable(cmd_write_disable),
        .cmd_read_status(cmd_read_status), .cmd_suspend(cmd_suspend),
        .cmd_resume(cmd_resume), .cmd_op(cmd_op), .cmd_reg_sel(cmd_reg_sel),
        .cmd_wdata(cmd_wdata), .wp_pin_n(wp_pin_n));
    wire logic [7:0] pins = {1'b0, wp_pin_active, shared_pin_hold, shared_pin_reset,
        quad_lane_enable,
        drive_level, fast_clock_mode};
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic idle();
        i_fsr_host_model.wait_idle(ok);
        chk("idle", {7'h0, ok}, 8'h01);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // About 330 cycles of tests expected; the limit leaves a wide margin
    initial begin
        #50000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        int ign0;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk("reg1", first_status_reg, FSR_REG1_RST);
        chk("reg2", second_status_reg, FSR_REG2_RST);
        chk("reg3", third_status_reg, FSR_REG3_RST);
        chk("pins", pins, 8'h60);
        $display("test reset done");
        i_fsr_host_model.pulse(0);
        settle();
        chk("reg1", first_status_reg, 8'h02);
        i_fsr_host_model.pulse(2);
        settle();
        chk("reg1", first_status_reg, 8'h00);
        i_fsr_host_model.op(FSR_OP_PROGRAM, 2'h3, 8'h00);
        settle();
        chk("reg1", first_status_reg, 8'h00);
        chk("started", 8'(st_cnt), 8'h00);
        $display("test latch done");
        i_fsr_host_model.wr(0, 2'h0, 8'h7f);
        #1;
        chk("busy", first_status_reg & 8'h03, 8'h01);
        ign0 = ign_cnt;
        i_fsr_host_model.pulse(6);
        i_fsr_host_model.pulse(0);
        idle();
        chk("ignored", 8'(ign_cnt - ign0), 8'h01);
        chk("reg1", first_status_reg, 8'h7c);
        for (int o = 1; o < 5; o++) begin
            i_fsr_host_model.pulse(0);
            i_fsr_host_model.op(fsr_op_e'(o), 2'h3, 8'h00);
            #1;
            chk("busy", first_status_reg & 8'h03, 8'h01);
            idle();
            chk("done", first_status_reg & 8'h03, 8'h00);
        end
        chk("started", 8'(st_cnt), 8'h05);
        $display("test operations done");
        i_fsr_host_model.wr(1, 2'h1, 8'hfe);
        settle();
        chk("reg2", second_status_reg, 8'h42);
        chk("busy", first_status_reg & 8'h01, 8'h00);
        chk("pins", pins, 8'h08);
        i_fsr_host_model.wr(1, 2'h2, 8'hff);
        settle();
        chk("reg3", third_status_reg, 8'hf0);
        chk("pins", pins, 8'h0f);
        i_fsr_host_model.wr(1, 2'h1, 8'h00);
        settle();
        chk("pins", pins, 8'h57);
        chk("started", 8'(st_cnt), 8'h05);
        $display("test volatile done");
        i_fsr_host_model.wr(0, 2'h1, 8'h38);
        idle();
        chk("reg2", second_status_reg, 8'h38);
        i_fsr_host_model.wr(0, 2'h1, 8'h00);
        idle();
        chk("reg2", second_status_reg, 8'h38);
        i_fsr_host_model.pulse(4);
        settle();
        chk("reg2", second_status_reg, 8'hb8);
        i_fsr_host_model.pulse(5);
        settle();
        chk("reg2", second_status_reg, 8'h38);
        i_fsr_host_model.pulse(7);
        settle();
        chk("reg1", first_status_reg, 8'h7c);
        chk("reg3", third_status_reg, 8'h00);
        $display("test reload done");
        i_fsr_host_model.wr(0, 2'h0, 8'h80);
        idle();
        i_fsr_host_model.set_wp(1'b0);
        i_fsr_host_model.wr(0, 2'h0, 8'h84);
        idle();
        chk("reg1", first_status_reg, 8'h80);
        i_fsr_host_model.wr(1, 2'h0, 8'h88);
        settle();
        chk("reg1", first_status_reg, 8'h80);
        i_fsr_host_model.set_wp(1'b1);
        i_fsr_host_model.wr(0, 2'h0, 8'h00);
        idle();
        chk("reg1", first_status_reg, 8'h00);
        i_fsr_host_model.wr(1, 2'h1, 8'h01);
        settle();
        i_fsr_host_model.wr(1, 2'h0, 8'h04);
        settle();
        chk("reg1", first_status_reg, 8'h00);
        $display("test protection done");
        complete_run();
    end
endmodule
